// ===== deep_fifo_pkg.sv
// shared constants and types for the deep dual-clock fifo flag block
// assumes the fifo module imports the whole package
package deep_fifo_pkg;

	// register byte offsets on the plain register port
	localparam logic [3:0] REG_AE_OFFSET = 4'h0;
	localparam logic [3:0] REG_AF_OFFSET = 4'h4;
	localparam logic [3:0] REG_STATUS    = 4'h8;
	localparam logic [3:0] REG_FILL      = 4'hc;

	// default almost-full / almost-empty offsets chosen by load_select
	localparam int DEF_OFFSET_LOW  = 'h7f;
	localparam int DEF_OFFSET_HIGH = 'h3ff;

	localparam int DATA_W = 9;

	// status register layout, bit 7 downward
	typedef struct packed {
		logic fall_through;
		logic almost_empty_n;
		logic almost_full_n;
		logic output_ready_n;
		logic empty_n;
		logic input_ready_n;
		logic full_n;
		logic half_full_n;
	} flags_t;

	localparam int STATUS_W = $bits(flags_t);

endpackage

// ===== deep_fifo_status_flags.sv
// deep 9-bit fifo with half-full, full/input-ready, empty/output-ready and
// programmable almost-full/almost-empty flags, standard and fall-through modes
// assumes write_clock_in and read_clock_in are slow pins sampled on clk_sys_in;
// each of their rising edges outside a pin reset becomes a one-cycle enable pulse here
//
// Contract
// [RQ1] half-full goes low on the filling write edge
// [RQ2] half-full returns high on the draining read edge
// [RQ3] standard mode: low after depth/2+1 writes
// [RQ4] fall-through: low after (depth-1)/2+2 writes
// [RQ5] half-full updated by both clocks, asynchronous
// [RQ6] data_out is nine bits wide
// [RQ7] full rises one write cycle after read
// [RQ8] empty rises one read cycle after write
// [RQ9] standard first word readable after one read cycle
// [RQ10] fall-through first word appears without read request
// [RQ11] input_ready falls one write cycle after read
// [RQ12] reader waits for empty high after retransmit
// [RQ13] at least two words before retransmit
// [RQ14] standard: at most depth-2 writes before retransmit
// [RQ15] fall-through retransmit done when output_ready low
// [RQ16] input_ready stays low during retransmit setup
// [RQ17] retransmit replays from first word in order
// [RQ18] almost-full rises one write cycle after reads
// [RQ19] almost-full changes on write edges only
// [RQ20] almost-empty rises one read cycle after writes
// [RQ21] fall-through output_ready low with first valid word
// [RQ22] almost-full low after depth minus offset writes
// [RQ23] pointers cross domains through synchroniser stages
// [RQ24] retransmit rewinds read pointer, write pointer kept
//
// The placing of the registers and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module deep_fifo_status_flags
	import deep_fifo_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	// system
	input  wire logic              clk_sys_in,
	input  wire logic              reset_in,
	// resets and straps from pins
	input  wire logic              master_reset_in,
	input  wire logic              partial_reset_in,
	input  wire logic              load_select_in,
	input  wire logic              fall_through_mode_in,
	// write port pins
	input  wire logic              write_clock_in,
	input  wire logic              write_enable_in,
	input  wire logic [DATA_W-1:0] data_in,
	// read port pins
	input  wire logic              read_clock_in,
	input  wire logic              read_enable_in,
	input  wire logic              retransmit_in,
	// register port
	input  wire logic [3:0]        reg_addr_in,
	input  wire logic [31:0]       reg_wdata_in,
	input  wire logic              reg_wr_in,
	input  wire logic              reg_rd_in,
	output logic      [31:0]       reg_rdata_out,
	// data and flags
	output logic      [DATA_W-1:0] data_out,
	output logic                   half_full_flag_n_out,
	output logic                   full_flag_n_out,
	output logic                   input_ready_n_out,
	output logic                   empty_flag_n_out,
	output logic                   output_ready_n_out,
	output logic                   almost_full_flag_n_out,
	output logic                   almost_empty_flag_n_out
);

	localparam int DEPTH = 2 ** ADDR_W;
	localparam int PTR_W = ADDR_W + 1;
	localparam int CNT_W = ADDR_W + 2;
	localparam int PIN_W = 9 + DATA_W;

	// two-flop sampling of every pin; stage one feeds stage two only
	logic [PIN_W-1:0] pin_s1_q;
	logic [PIN_W-1:0] pin_s2_q;
	logic             wclk_prev_q;
	logic             rclk_prev_q;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			pin_s1_q    <= '0;
			pin_s2_q    <= '0;
			wclk_prev_q <= 1'b0;
			rclk_prev_q <= 1'b0;
		end else begin
			pin_s1_q    <= {master_reset_in, partial_reset_in, load_select_in,
				fall_through_mode_in, write_clock_in, write_enable_in,
				read_clock_in, read_enable_in, retransmit_in, data_in};
			pin_s2_q    <= pin_s1_q;
			wclk_prev_q <= pin_s2_q[DATA_W+4];
			rclk_prev_q <= pin_s2_q[DATA_W+2];
		end
	end

	logic              mrst;
	logic              prst;
	logic              any_rst;
	logic              ld_s;
	logic              ftm_s;
	logic              wen_s;
	logic              ren_s;
	logic [DATA_W-1:0] din_s;
	logic              wr_evt;
	logic              rd_evt;
	logic              rt_s;

	assign mrst    = pin_s2_q[DATA_W+8];
	assign prst    = pin_s2_q[DATA_W+7];
	assign any_rst = mrst | prst;
	assign ld_s    = pin_s2_q[DATA_W+6];
	assign ftm_s   = pin_s2_q[DATA_W+5];
	assign wen_s   = pin_s2_q[DATA_W+3];
	// retransmit has its own slot just below read enable; read is masked while it is high
	assign ren_s   = pin_s2_q[DATA_W+1] & ~pin_s2_q[DATA_W];
	assign din_s   = pin_s2_q[DATA_W-1:0];
	assign rt_s    = pin_s2_q[DATA_W];
	assign wr_evt  = pin_s2_q[DATA_W+4] & ~wclk_prev_q & ~any_rst;
	assign rd_evt  = pin_s2_q[DATA_W+2] & ~rclk_prev_q & ~any_rst;

	// mode strap and offsets; partial reset keeps both
	logic              ftm_q;
	logic [ADDR_W-1:0] ae_off_q;
	logic [ADDR_W-1:0] af_off_q;

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			ftm_q    <= 1'b0;
			ae_off_q <= ADDR_W'(DEF_OFFSET_LOW);
			af_off_q <= ADDR_W'(DEF_OFFSET_LOW);
		end else if (mrst) begin
			ftm_q    <= ftm_s;
			ae_off_q <= ld_s ? ADDR_W'(DEF_OFFSET_HIGH)
				: ADDR_W'(DEF_OFFSET_LOW);
			af_off_q <= ld_s ? ADDR_W'(DEF_OFFSET_HIGH)
				: ADDR_W'(DEF_OFFSET_LOW);
		end else if (reg_wr_in) begin
			if (reg_addr_in == REG_AE_OFFSET)
				ae_off_q <= reg_wdata_in[ADDR_W-1:0];
			if (reg_addr_in == REG_AF_OFFSET)
				af_off_q <= reg_wdata_in[ADDR_W-1:0];
		end
	end

	// storage and pointers
	logic [DATA_W-1:0] mem [DEPTH];
	logic [PTR_W-1:0]  wr_ptr_q;
	logic [PTR_W-1:0]  rd_ptr_q;
	logic              out_valid_q;
	// views of the far pointer, refreshed on the near clock's edges
	logic [PTR_W-1:0]  rd_wside_q;
	logic              ov_wside_q;
	logic [PTR_W-1:0]  wr_rside_q;

	// write side: counts seen by the write clock
	logic [PTR_W-1:0] diff_w;
	logic [CNT_W-1:0] fill_w;
	logic             wr_ok;
	logic [CNT_W-1:0] fill_w_next;

	always_comb begin
		diff_w      = wr_ptr_q - rd_wside_q;
		fill_w      = {1'b0, diff_w} + CNT_W'(ftm_q & ov_wside_q);
		wr_ok       = wen_s & (diff_w < PTR_W'(DEPTH));
		fill_w_next = fill_w + CNT_W'(wr_ok);
	end

	// read side: counts seen by the read clock
	logic [PTR_W-1:0] diff_r;
	logic             pop;
	logic             ov_d;
	logic [PTR_W-1:0] rd_ptr_d;
	logic [PTR_W-1:0] diff_r_next;
	logic [CNT_W-1:0] fill_r_next;
	logic             rd_take;

	always_comb begin
		diff_r   = wr_rside_q - rd_ptr_q;
		pop      = 1'b0;
		ov_d     = out_valid_q;
		rd_ptr_d = rd_ptr_q;
		if (rt_s) begin
			rd_ptr_d = '0; // see [RQ24]
			ov_d     = 1'b0;
		end else if (ftm_q) begin
			// word falls through with no read request, see [RQ10]
			if ((!out_valid_q || ren_s) && diff_r != '0) begin
				pop  = 1'b1;
				ov_d = 1'b1;
			end else if (ren_s) begin
				ov_d = 1'b0;
			end
		end else if (ren_s && diff_r != '0) begin
			pop = 1'b1; // see [RQ9]
		end
		if (pop)
			rd_ptr_d = rd_ptr_q + PTR_W'(1);
		// only a consumed word may clear half-full; idle edges see stale counts
		rd_take  = ftm_q ? (ren_s & out_valid_q) : pop;
		diff_r_next = wr_rside_q - rd_ptr_d;
		fill_r_next = {1'b0, diff_r_next} + CNT_W'(ftm_q & ov_d);
	end

	always_ff @(posedge clk_sys_in) begin
		if (wr_evt && wr_ok)
			mem[wr_ptr_q[ADDR_W-1:0]] <= din_s;
	end

	// a rewind of the read side needs no write pointer reload
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			wr_ptr_q <= '0;
		else if (any_rst)
			wr_ptr_q <= '0;
		else if (wr_evt && wr_ok)
			wr_ptr_q <= wr_ptr_q + PTR_W'(1);
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rd_ptr_q    <= '0;
			out_valid_q <= 1'b0;
			data_out    <= '0;
		end else if (any_rst) begin
			rd_ptr_q    <= '0;
			out_valid_q <= 1'b0;
			data_out    <= '0;
		end else if (rd_evt) begin
			rd_ptr_q    <= rd_ptr_d; // see [RQ17]
			out_valid_q <= ov_d;
			if (pop)
				data_out <= mem[rd_ptr_q[ADDR_W-1:0]]; // see [RQ6]
		end
	end

	// pointer hand-over: one stage refreshed on each near edge, flags then register it,
	// which bounds the latency to one near cycle plus one when edges crowd
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			rd_wside_q <= '0;
			ov_wside_q <= 1'b0;
		end else if (any_rst) begin
			rd_wside_q <= '0;
			ov_wside_q <= 1'b0;
		end else if (wr_evt) begin
			rd_wside_q <= rd_ptr_q; // see [RQ23]
			ov_wside_q <= out_valid_q;
		end
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in)
			wr_rside_q <= '0;
		else if (any_rst)
			wr_rside_q <= '0;
		else if (rd_evt)
			wr_rside_q <= wr_ptr_q; // see [RQ23]
	end

	// thresholds; fall-through counts the output word, so depth is one more
	logic [CNT_W-1:0] half_lim;
	logic [CNT_W-1:0] full_lim;
	logic [CNT_W-1:0] af_lim;
	logic [CNT_W-1:0] ae_lim;

	always_comb begin
		half_lim = CNT_W'(DEPTH / 2) + CNT_W'(ftm_q); // see [RQ3] [RQ4]
		full_lim = CNT_W'(DEPTH) + CNT_W'(ftm_q);
		af_lim   = full_lim - {2'b00, af_off_q}; // see [RQ22]
		ae_lim   = {2'b00, ae_off_q} + CNT_W'(ftm_q);
	end

	// write-clock flags: full / input-ready and almost-full
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			full_flag_n_out        <= 1'b1;
			input_ready_n_out      <= 1'b1;
			almost_full_flag_n_out <= 1'b1;
		end else if (any_rst) begin
			full_flag_n_out        <= 1'b1;
			input_ready_n_out      <= ~ftm_q;
			almost_full_flag_n_out <= 1'b1;
		end else if (wr_evt) begin
			// see [RQ7] [RQ11] [RQ16]
			full_flag_n_out        <= ftm_q | (fill_w_next < full_lim);
			input_ready_n_out      <= ~ftm_q | (fill_w_next >= full_lim);
			// see [RQ18] [RQ19]
			almost_full_flag_n_out <= fill_w_next < af_lim;
		end
	end

	// read-clock flags: empty / output-ready and almost-empty
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			empty_flag_n_out        <= 1'b0;
			output_ready_n_out      <= 1'b1;
			almost_empty_flag_n_out <= 1'b0;
		end else if (any_rst) begin
			empty_flag_n_out        <= ftm_q;
			output_ready_n_out      <= 1'b1;
			almost_empty_flag_n_out <= 1'b0;
		end else if (rd_evt) begin
			// in standard mode retransmit holds empty low for one edge as its setup, see [RQ8]
			empty_flag_n_out        <= ftm_q | (!rt_s && diff_r_next != '0);
			// see [RQ15] [RQ21]
			output_ready_n_out      <= ~ftm_q | ~ov_d;
			almost_empty_flag_n_out <= fill_r_next > ae_lim; // see [RQ20]
		end
	end

	// half-full is moved by both edges; a coincident write edge wins
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			half_full_flag_n_out <= 1'b1;
		end else if (any_rst) begin
			half_full_flag_n_out <= 1'b1;
		end else begin
			// see [RQ5]
			if (rd_evt && rd_take && fill_r_next <= half_lim)
				half_full_flag_n_out <= 1'b1; // see [RQ2]
			if (wr_evt && wr_ok && fill_w_next > half_lim)
				half_full_flag_n_out <= 1'b0; // see [RQ1]
		end
	end

	// register readback, one cycle after the read strobe
	flags_t status;

	always_comb begin
		status = '{
			fall_through:   ftm_q,
			almost_empty_n: almost_empty_flag_n_out,
			almost_full_n:  almost_full_flag_n_out,
			output_ready_n: output_ready_n_out,
			empty_n:        empty_flag_n_out,
			input_ready_n:  input_ready_n_out,
			full_n:         full_flag_n_out,
			half_full_n:    half_full_flag_n_out
		};
	end

	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			case (reg_addr_in)
				REG_AE_OFFSET: reg_rdata_out <= 32'(ae_off_q);
				REG_AF_OFFSET: reg_rdata_out <= 32'(af_off_q);
				REG_STATUS:    reg_rdata_out <= 32'(status);
				REG_FILL:      reg_rdata_out <= 32'(fill_w);
				default:       reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

endmodule

`default_nettype wire

// ===== deep_fifo_flags_chk.sv
// checker on the flag pins and register read port of the fifo
// assumes pin clocks are slow and sampled on clk_sys_in
`timescale 1ns/10ps
`default_nettype none
module deep_fifo_flags_chk
	import deep_fifo_pkg::*;
#(
	parameter int ADDR_W = 18
) (
	input wire logic              clk_sys_in,
	input wire logic              reset_in,
	input wire logic              master_reset_in,
	input wire logic              partial_reset_in,
	input wire logic              write_clock_in,
	input wire logic              read_clock_in,
	input wire logic              reg_wr_in,
	input wire logic              reg_rd_in,
	input wire logic [31:0]       reg_rdata_out,
	input wire logic [DATA_W-1:0] data_out,
	input wire logic              half_full_flag_n_out,
	input wire logic              full_flag_n_out,
	input wire logic              input_ready_n_out,
	input wire logic              empty_flag_n_out,
	input wire logic              output_ready_n_out,
	input wire logic              almost_full_flag_n_out,
	input wire logic              almost_empty_flag_n_out
);
	logic       wclk_q, rclk_q;
	logic [3:0] wr_age_q, rd_age_q, rst_age_q;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (reset_in);
	// ages since a pin clock rise, a pin reset or a register write; a flag may only move a few cycles after one
	always_ff @(posedge clk_sys_in or posedge reset_in) begin
		if (reset_in) begin
			wclk_q <= 1'b0;
			rclk_q <= 1'b0;
			wr_age_q <= 4'h0;
			rd_age_q <= 4'h0;
			rst_age_q <= 4'h0;
		end else begin
			wclk_q <= write_clock_in;
			rclk_q <= read_clock_in;
			wr_age_q <= (write_clock_in && !wclk_q) ? 4'h0 :
				wr_age_q + {3'h0, wr_age_q != 4'hf};
			rd_age_q <= (read_clock_in && !rclk_q) ? 4'h0 :
				rd_age_q + {3'h0, rd_age_q != 4'hf};
			// offset writes may move the programmable flags too
			rst_age_q <= (master_reset_in || partial_reset_in || reg_wr_in) ?
				4'h0 : rst_age_q + {3'h0, rst_age_q != 4'hf};
		end
	end
	rdata_idle_a: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
		else $error("read data outside its cycle");
	full_wr_edge_a: assert property ($changed(full_flag_n_out) |->
		wr_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("full moved off edge");
	ir_wr_edge_a: assert property ($changed(input_ready_n_out) |->
		wr_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("ready moved off edge");
	af_wr_edge_a: assert property ($changed(almost_full_flag_n_out) |->
		wr_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("almost full off edge");
	empty_rd_edge_a: assert property ($changed(empty_flag_n_out) |->
		rd_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("empty moved off edge");
	ae_rd_edge_a: assert property ($changed(almost_empty_flag_n_out) |->
		rd_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("almost empty off edge");
	dout_rd_edge_a: assert property ($changed(data_out) |->
		rd_age_q <= 4'h6 || rst_age_q <= 4'h6) else $error("data moved off edge");
	hf_edge_a: assert property ($changed(half_full_flag_n_out) |->
		wr_age_q <= 4'h6 || rd_age_q <= 4'h6 || rst_age_q <= 4'h6)
		else $error("half full moved off any edge");
	mode_split_a: assert property (!full_flag_n_out || !empty_flag_n_out |->
		input_ready_n_out && output_ready_n_out) else $error("mode flags mixed");
endmodule
bind deep_fifo_status_flags deep_fifo_flags_chk #(.ADDR_W(ADDR_W))
	deep_fifo_flags_chk_inst (
	.clk_sys_in(clk_sys_in),
	.reset_in(reset_in),
	.master_reset_in(master_reset_in),
	.partial_reset_in(partial_reset_in),
	.write_clock_in(write_clock_in),
	.read_clock_in(read_clock_in),
	.reg_wr_in(reg_wr_in),
	.reg_rd_in(reg_rd_in),
	.reg_rdata_out(reg_rdata_out),
	.data_out(data_out),
	.half_full_flag_n_out(half_full_flag_n_out),
	.full_flag_n_out(full_flag_n_out),
	.input_ready_n_out(input_ready_n_out),
	.empty_flag_n_out(empty_flag_n_out),
	.output_ready_n_out(output_ready_n_out),
	.almost_full_flag_n_out(almost_full_flag_n_out),
	.almost_empty_flag_n_out(almost_empty_flag_n_out));
`default_nettype wire

// ===== deep_fifo_far_side.sv
// writer and reader logic driving the fifo pin clocks
// assumes one pulse task call at a time; pin clocks stand still between calls
`timescale 1ns/10ps
`default_nettype none
module deep_fifo_far_side
	import deep_fifo_pkg::*;
(
	// system
	input  wire logic        clk_sys_in,
	// write side
	output logic             write_clock_out,
	output logic             write_enable_out,
	output logic [DATA_W-1:0] write_data_out,
	// read side
	output logic             read_clock_out,
	output logic             read_enable_out,
	output logic             retransmit_out
);
	initial begin
		write_clock_out = 1'b0;
		write_enable_out = 1'b0;
		write_data_out = '0;
		read_clock_out = 1'b0;
		read_enable_out = 1'b0;
		retransmit_out = 1'b0;
	end
	// one pin clock period of 13 sys cycles, qualifiers set 4 before the rise and held 8 after it
	task automatic pulse(input logic wr_side, input logic en,
		input logic [DATA_W-1:0] d, input logic rt);
		@(posedge clk_sys_in);
		write_enable_out <= wr_side & en;
		write_data_out <= d;
		read_enable_out <= !wr_side & en;
		retransmit_out <= !wr_side & rt;
		repeat (4) @(posedge clk_sys_in);
		write_clock_out <= wr_side;
		read_clock_out <= !wr_side;
		repeat (4) @(posedge clk_sys_in);
		write_clock_out <= 1'b0;
		read_clock_out <= 1'b0;
		repeat (4) @(posedge clk_sys_in);
		write_enable_out <= 1'b0;
		// idle data is inverted so a stale word never looks valid
		write_data_out <= ~d;
		read_enable_out <= 1'b0;
		retransmit_out <= 1'b0;
	endtask
endmodule
`default_nettype wire

// ===== deep_fifo_status_flags_tb.sv
// testbench for the fifo flag block, depth cut to 16 words
// assumes the far side model and the bound checker are compiled with it
`timescale 1ns/10ps
`default_nettype none
module deep_fifo_status_flags_tb;
	import deep_fifo_pkg::*;
	logic clk_sys_in = 1'b0, reset_in = 1'b1;
	logic master_reset_in = 1'b0, partial_reset_in = 1'b0;
	logic load_select_in = 1'b0, fall_through_mode_in = 1'b0;
	logic [3:0]  reg_addr_in = 4'h0;
	logic [31:0] reg_wdata_in = 32'h0, reg_rdata_out;
	logic reg_wr_in = 1'b0, reg_rd_in = 1'b0;
	logic write_clock_in, write_enable_in, read_clock_in, read_enable_in;
	logic retransmit_in, half_full_flag_n_out, full_flag_n_out;
	logic input_ready_n_out, empty_flag_n_out, output_ready_n_out;
	logic almost_full_flag_n_out, almost_empty_flag_n_out;
	logic [DATA_W-1:0] data_in, data_out;
	int err_total = 0, check_count = 0;
	always #25 clk_sys_in = ~clk_sys_in;
	deep_fifo_status_flags #(.ADDR_W(4)) deep_fifo_status_flags_inst (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.master_reset_in(master_reset_in),
		.partial_reset_in(partial_reset_in),
		.load_select_in(load_select_in),
		.fall_through_mode_in(fall_through_mode_in),
		.write_clock_in(write_clock_in),
		.write_enable_in(write_enable_in),
		.data_in(data_in),
		.read_clock_in(read_clock_in),
		.read_enable_in(read_enable_in),
		.retransmit_in(retransmit_in),
		.reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in),
		.reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in),
		.reg_rdata_out(reg_rdata_out),
		.data_out(data_out),
		.half_full_flag_n_out(half_full_flag_n_out),
		.full_flag_n_out(full_flag_n_out),
		.input_ready_n_out(input_ready_n_out),
		.empty_flag_n_out(empty_flag_n_out),
		.output_ready_n_out(output_ready_n_out),
		.almost_full_flag_n_out(almost_full_flag_n_out),
		.almost_empty_flag_n_out(almost_empty_flag_n_out));
	deep_fifo_far_side deep_fifo_far_side_inst (.clk_sys_in(clk_sys_in),
		.write_clock_out(write_clock_in), .write_enable_out(write_enable_in),
		.write_data_out(data_in), .read_clock_out(read_clock_in),
		.read_enable_out(read_enable_in), .retransmit_out(retransmit_in));
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			$display("unexpected %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask
	task automatic wr(input logic en, input logic [DATA_W-1:0] d);
		deep_fifo_far_side_inst.pulse(1'b1, en, d, 1'b0);
	endtask
	task automatic rd(input logic en, input logic rt);
		deep_fifo_far_side_inst.pulse(1'b0, en, '0, rt);
	endtask
	task automatic reg_io(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_sys_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= w;
		reg_rd_in <= !w;
		@(posedge clk_sys_in);
		reg_wr_in <= 1'b0;
		reg_rd_in <= 1'b0;
		#1 q = reg_rdata_out;
	endtask
	task automatic pin_reset(input logic part, input logic ft);
		@(posedge clk_sys_in);
		fall_through_mode_in <= ft;
		master_reset_in <= !part;
		partial_reset_in <= part;
		repeat (6) @(posedge clk_sys_in);
		master_reset_in <= 1'b0;
		partial_reset_in <= 1'b0;
		repeat (5) @(posedge clk_sys_in);
	endtask
	// idle read edges until setup ends; a retransmit may not be read before
	task automatic wait_ready(input logic ft);
		int n;
		for (n = 0; n < 8; n++) begin
			if (ft ? output_ready_n_out === 1'b0 : empty_flag_n_out === 1'b1)
				break;
			rd(1'b0, 1'b0);
		end
		if (n == 8) begin
			chk("setup wait", 1, 0);
			wrap_up();
		end
	endtask
	initial begin
		logic [31:0] v;
		int i;
		repeat (10) @(posedge clk_sys_in);
		reset_in <= 1'b0;
		pin_reset(1'b0, 1'b0);
		reg_io(1'b0, 4'h8, 32'h0, v);
		chk("status", 32'h37, v);
		reg_io(1'b0, 4'h2, 32'h0, v);
		chk("unmapped", 32'h0, v);
		reg_io(1'b1, 4'h4, 32'h4, v);
		reg_io(1'b1, 4'h0, 32'h2, v);
		reg_io(1'b0, 4'h4, 32'h0, v);
		chk("full offset", 32'h4, v);
		$display("test reset and registers done");
		for (i = 1; i <= 16; i++) begin
			wr(1'b1, 9'h100 | i[8:0]);
			chk("half full", i <= 8, half_full_flag_n_out);
			chk("almost full", i < 12, almost_full_flag_n_out);
			chk("full", i < 16, full_flag_n_out);
		end
		wr(1'b1, 9'h0ff);
		reg_io(1'b0, 4'hc, 32'h0, v);
		chk("fill", 32'h10, v);
		rd(1'b0, 1'b0);
		rd(1'b0, 1'b0);
		chk("empty", 1, empty_flag_n_out);
		chk("almost empty", 1, almost_empty_flag_n_out);
		for (i = 1; i <= 16; i++) begin
			rd(1'b1, 1'b0);
			chk("word", 9'h100 | i[8:0], data_out);
			if (i == 1) wr(1'b0, 9'h0);
			if (i == 1) wr(1'b0, 9'h0);
			if (i == 1) chk("full", 1, full_flag_n_out);
		end
		chk("half full", 1, half_full_flag_n_out);
		rd(1'b0, 1'b0);
		rd(1'b0, 1'b0);
		wr(1'b0, 9'h0);
		wr(1'b0, 9'h0);
		chk("empty", 0, empty_flag_n_out);
		chk("almost empty", 0, almost_empty_flag_n_out);
		chk("almost full", 1, almost_full_flag_n_out);
		$display("test standard fill and drain done");
		pin_reset(1'b1, 1'b0);
		for (i = 1; i <= 3; i++) wr(1'b1, 9'h0a0 + i[8:0]);
		rd(1'b0, 1'b0);
		rd(1'b0, 1'b0);
		rd(1'b1, 1'b0);
		rd(1'b0, 1'b1);
		wait_ready(1'b0);
		for (i = 1; i <= 3; i++) begin
			rd(1'b1, 1'b0);
			chk("replay", 9'h0a0 + i[8:0], data_out);
		end
		$display("test standard retransmit done");
		pin_reset(1'b0, 1'b1);
		reg_io(1'b0, 4'h8, 32'h0, v);
		chk("mode", 32'h80, v & 32'h80);
		wr(1'b1, 9'h155);
		wr(1'b1, 9'h0aa);
		rd(1'b0, 1'b0);
		rd(1'b0, 1'b0);
		chk("output ready", 0, output_ready_n_out);
		chk("fall word", 9'h155, data_out);
		rd(1'b1, 1'b0);
		chk("next word", 9'h0aa, data_out);
		rd(1'b0, 1'b1);
		chk("input ready", 0, input_ready_n_out);
		wait_ready(1'b1);
		chk("fall replay", 9'h155, data_out);
		chk("input ready", 0, input_ready_n_out);
		// fill to depth plus the output word, then free one place
		for (i = 1; i <= 15; i++) begin
			wr(1'b1, 9'h040 + i[8:0]);
			chk("input ready", i == 15, input_ready_n_out);
		end
		rd(1'b1, 1'b0);
		chk("second word", 9'h0aa, data_out);
		wr(1'b0, 9'h0);
		chk("input ready", 1, input_ready_n_out);
		wr(1'b0, 9'h0);
		chk("input ready", 0, input_ready_n_out);
		$display("test fall through done");
		wrap_up();
	end
endmodule
`default_nettype wire
